// ---- logic/dpso_pkg.sv ----
/*
   dpso_pkg: constants, register map and carrier types of the drive
   protection and status-output block.
   assumes: 200 MHz pclk, apb slave with 32-bit data.
*/
package dpso_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] DPSO_CTRL_OFS = 8'h00;    // enables and mode
   localparam logic [7:0] DPSO_DUTY_OFS = 8'h04;    // square-wave duty
   localparam logic [7:0] DPSO_OLTH_OFS = 8'h08;    // overload threshold
   localparam logic [7:0] DPSO_OLFT_OFS = 8'h0c;    // overload filter time
   localparam logic [7:0] DPSO_GRAV_OFS = 8'h10;    // gravity torque offset
   localparam logic [7:0] DPSO_STAT_OFS = 8'h14;    // status, read only
   localparam logic [7:0] DPSO_ACODE_OFS = 8'h18;   // active alarm code

   // control field positions
   localparam int DPSO_CTRL_PL_BIT = 0;     // phase-loss enable
   localparam int DPSO_CTRL_EB_BIT = 1;     // encoder-break enable
   localparam int DPSO_CTRL_SQ_BIT = 2;     // fault output square mode

   // reset values
   localparam logic DPSO_PL_EN_RST = 1'b1;
   localparam logic DPSO_EB_EN_RST = 1'b1;
   localparam logic [6:0] DPSO_DUTY_RST = 7'h64;        // 100 percent
   localparam logic [6:0] DPSO_DUTY_MIN = 7'h01;
   localparam logic [6:0] DPSO_DUTY_MAX = 7'h64;
   localparam logic [9:0] DPSO_OLTH_RST = 10'h078;      // 120 percent
   localparam logic [9:0] DPSO_OLTH_MAX = 10'h320;      // 800 percent
   localparam logic [9:0] DPSO_OLFT_RST = 10'h00a;      // 10 x 10 ms
   localparam logic [9:0] DPSO_OLFT_MAX = 10'h3e8;      // 1000
   localparam logic signed [10:0] DPSO_GRAV_MAX = 11'sd1000;
   localparam logic signed [10:0] DPSO_GRAV_MIN = -11'sd1000;

   // alarm codes as shown on the display
   localparam logic [7:0] DPSO_PHASE_LOSS_ALARM_CODE = 8'h06;
   localparam logic [7:0] DPSO_ENCODER_BREAK_ALARM_CODE = 8'h11;

   // timing
   localparam int DPSO_CLK_MHZ = 200;
   localparam int DPSO_FILT_UNIT_MS = 10;
   localparam int DPSO_FILT_UNIT_CYC = DPSO_FILT_UNIT_MS * 1000 * DPSO_CLK_MHZ;
   localparam int DPSO_SQ_PERIOD_US = 1000;
   localparam int DPSO_SQ_PERIOD_CYC = DPSO_SQ_PERIOD_US * DPSO_CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////////
   // settings carried from the register file to the logic
   typedef struct packed {
      logic pl_en;               // phase-loss protect enable
      logic eb_en;               // encoder-break protect enable
      logic sq_mode;             // fault output as square wave
      logic [6:0] duty;          // duty in percent
      logic [9:0] ol_thresh;     // overload threshold percent
      logic [9:0] ol_filt;       // filter time in 10 ms units
      logic signed [10:0] grav;  // gravity offset, 0.1 percent rated
   } dpso_cfg_t;

   // plant condition inputs
   typedef struct packed {
      logic phase_lost;          // supply phase missing
      logic enc_broken;          // encoder cable break or miswire
      logic other_fault;         // any other drive fault
      logic ctrl_pwr_ok;         // control supply normal
      logic main_pwr_ok;         // main supply normal
      logic cmd_ready;           // able to accept commands
      logic speed_limited;       // speed clamp active, either direction
   } dpso_cond_t;

endpackage : dpso_pkg

// ---- logic/dpso_sq_gen.sv ----
/*
   dpso_sq_gen: fixed-period square wave whose high time is a percentage.
   assumes: duty already clamped to 1..100 by the caller.
*/
`timescale 1ns/1ps
module dpso_sq_gen
   import dpso_pkg::*;
#(
   parameter int PERIOD_CYC = DPSO_SQ_PERIOD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [6:0] duty,
   output logic wave
);
   localparam int STEP = PERIOD_CYC / 100;    // cycles per percent
   logic [31:0] cnt;                          // position in period
   logic [31:0] high_cyc;                     // high time in cycles

   ////////////////////////////////////////////////////////////////////////////
   // period counter; free-running so duty changes act at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 32'h0;
      end else if (ce) begin
         if (cnt >= 32'(PERIOD_CYC - 1)) begin
            cnt <= 32'h0;
         end else begin
            cnt <= cnt + 32'h1;
         end
      end
   end

   // high for duty percent of the period
   assign high_cyc = 32'(duty) * 32'(STEP);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave <= 1'b1;
      end else if (ce) begin
         wave <= (cnt < high_cyc);
      end
   end

endmodule : dpso_sq_gen

// ---- logic/dpso_ol_filt.sv ----
/*
   dpso_ol_filt: overload warning with a qualifying filter time.
   assumes: current and threshold in the same percent scale.
*/
`timescale 1ns/1ps
module dpso_ol_filt
   import dpso_pkg::*;
#(
   parameter int UNIT_CYC = DPSO_FILT_UNIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [9:0] current,
   input wire logic [9:0] thresh,
   input wire logic [9:0] filt,
   output logic warn
);
   logic over;              // current at or above threshold
   logic [31:0] sub_cnt;    // cycles within one 10 ms unit
   logic [9:0] unit_cnt;    // elapsed units
   logic unit_tick;         // end of a unit

   assign over = (current >= thresh);
   assign unit_tick = (sub_cnt >= 32'(UNIT_CYC - 1));

   ////////////////////////////////////////////////////////////////////////////
   // elapsed-time counters; any dip below restarts them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_cnt <= 32'h0;
         unit_cnt <= 10'h0;
      end else if (ce) begin
         if (!over) begin
            sub_cnt <= 32'h0;
            unit_cnt <= 10'h0;
         end else if (unit_cnt < filt) begin
            if (unit_tick) begin
               sub_cnt <= 32'h0;
               unit_cnt <= unit_cnt + 10'h1;
            end else begin
               sub_cnt <= sub_cnt + 32'h1;
            end
         end
      end
   end

   // warn once the filter has run out with current still high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn <= 1'b0;
      end else if (ce) begin
         warn <= over && (unit_cnt >= filt);
      end
   end

   a_ol_clear_below: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !over |=> !warn) else $error("warning held with current below threshold");
   a_ol_needs_over: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(warn) |-> $past(over)) else $error("warning rose without overcurrent");

endmodule : dpso_ol_filt

// ---- logic/dpso_top.sv ----
/*
   dpso_top: protection alarms and discrete status outputs of the drive,
   with an apb register file for the settings.
   assumes: plant conditions and current are synchronous to pclk.
*/
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module dpso_top
   import dpso_pkg::*;
#(
   parameter int SQ_PERIOD_CYC = DPSO_SQ_PERIOD_CYC,
   parameter int FILT_UNIT_CYC = DPSO_FILT_UNIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // plant side
   input wire dpso_cond_t cond,
   input wire logic [9:0] out_current,
   // discrete outputs
   output logic fault_alarm_output,
   output logic drive_ready_output,
   output logic overload_warning_output,
   output logic speed_limit_output,
   output logic signed [10:0] gravity_torque_offset,
   output logic [7:0] alarm_code
);

   ////////////////////////////////////////////////////////////////////////////
   // register state
   dpso_cfg_t cfg;           // settings from software
   logic phase_alarm;        // latched phase-loss alarm
   logic enc_alarm;          // latched encoder-break alarm
   logic any_fault;          // any alarm present
   logic sq_wave;            // square wave from generator
   logic ol_warn;            // filtered overload warning
   logic wr_en;              // apb write strike
   logic rd_en;              // apb read strike
   logic addr_ok;            // address maps to a register
   logic [31:0] next_rdata;  // read mux

   // one-cycle access phase: always ready
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite && ce;
   // read data is loaded in the setup cycle so that it already stands at the access edge
   assign rd_en = psel && !penable && !pwrite && ce;

   always_comb begin
      addr_ok = 1'b1;
      next_rdata = 32'h0;
      unique case (paddr)
         DPSO_CTRL_OFS: next_rdata = {29'h0, cfg.sq_mode, cfg.eb_en, cfg.pl_en};
         DPSO_DUTY_OFS: next_rdata = {25'h0, cfg.duty};
         DPSO_OLTH_OFS: next_rdata = {22'h0, cfg.ol_thresh};
         DPSO_OLFT_OFS: next_rdata = {22'h0, cfg.ol_filt};
         DPSO_GRAV_OFS: next_rdata = {{21{cfg.grav[10]}}, cfg.grav};
         DPSO_STAT_OFS: next_rdata = {26'h0, speed_limit_output, overload_warning_output,
                                      drive_ready_output, fault_alarm_output, enc_alarm, phase_alarm};
         DPSO_ACODE_OFS: next_rdata = {24'h0, alarm_code};
         default: addr_ok = 1'b0;  // unmapped: error, zero data
      endcase
   end

   // error only during the access phase of an unmapped address
   assign pslverr = psel && penable && !addr_ok;

   ////////////////////////////////////////////////////////////////////////////
   // read data register, loaded at the setup edge; the master holds the
   // address through the access phase, so the word matches what it asked for
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_en) begin
         prdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings; out-of-range writes are clamped so the hardware
   // never runs on a value the setting range forbids
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg.pl_en <= DPSO_PL_EN_RST;
         cfg.eb_en <= DPSO_EB_EN_RST;
         cfg.sq_mode <= 1'b0;
         cfg.duty <= DPSO_DUTY_RST;
         cfg.ol_thresh <= DPSO_OLTH_RST;
         cfg.ol_filt <= DPSO_OLFT_RST;
         cfg.grav <= 11'sd0;
      end else if (wr_en) begin
         unique case (paddr)
            DPSO_CTRL_OFS: begin
               cfg.pl_en <= pwdata[DPSO_CTRL_PL_BIT];
               cfg.eb_en <= pwdata[DPSO_CTRL_EB_BIT];
               cfg.sq_mode <= pwdata[DPSO_CTRL_SQ_BIT];
            end
            DPSO_DUTY_OFS: begin
               if (pwdata[6:0] < DPSO_DUTY_MIN || pwdata[31:7] != 25'h0) begin
                  cfg.duty <= (pwdata[31:7] != 25'h0) ? DPSO_DUTY_MAX : DPSO_DUTY_MIN;
               end else if (pwdata[6:0] > DPSO_DUTY_MAX) begin
                  cfg.duty <= DPSO_DUTY_MAX;
               end else begin
                  cfg.duty <= pwdata[6:0];
               end
            end
            DPSO_OLTH_OFS: begin
               cfg.ol_thresh <= (pwdata > 32'(DPSO_OLTH_MAX)) ? DPSO_OLTH_MAX : pwdata[9:0];
            end
            DPSO_OLFT_OFS: begin
               cfg.ol_filt <= (pwdata > 32'(DPSO_OLFT_MAX)) ? DPSO_OLFT_MAX : pwdata[9:0];
            end
            DPSO_GRAV_OFS: begin
               if ($signed(pwdata) > 32'(DPSO_GRAV_MAX)) begin
                  cfg.grav <= DPSO_GRAV_MAX;
               end else if ($signed(pwdata) < $signed(32'(DPSO_GRAV_MIN))) begin
                  cfg.grav <= DPSO_GRAV_MIN;
               end else begin
                  cfg.grav <= pwdata[10:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // protection alarms; an alarm stays until reset because the
   // drive must be serviced, while disabling the protection drops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_alarm <= 1'b0;
      end else if (ce) begin
         if (!cfg.pl_en) begin
            phase_alarm <= 1'b0;
         end else if (cond.phase_lost) begin
            phase_alarm <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enc_alarm <= 1'b0;
      end else if (ce) begin
         if (!cfg.eb_en) begin
            enc_alarm <= 1'b0;
         end else if (cond.enc_broken) begin
            enc_alarm <= 1'b1;
         end
      end
   end

   // displayed code: phase loss has priority as the supply fault
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_code <= 8'h00;
      end else if (ce) begin
         if (phase_alarm) begin
            alarm_code <= DPSO_PHASE_LOSS_ALARM_CODE;
         end else if (enc_alarm) begin
            alarm_code <= DPSO_ENCODER_BREAK_ALARM_CODE;
         end else begin
            alarm_code <= 8'h00;
         end
      end
   end

   assign any_fault = phase_alarm || enc_alarm || cond.other_fault;

   ////////////////////////////////////////////////////////////////////////////
   // fault output; in square mode the healthy state toggles at the duty
   dpso_sq_gen #(
      .PERIOD_CYC(SQ_PERIOD_CYC)
   ) u_sq (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .duty(cfg.duty),
      .wave(sq_wave)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_alarm_output <= 1'b0;
      end else if (ce) begin
         if (any_fault) begin
            fault_alarm_output <= 1'b0;
         end else begin
            fault_alarm_output <= cfg.sq_mode ? sq_wave : 1'b1;
         end
      end
   end

   // ready output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_ready_output <= 1'b0;
      end else if (ce) begin
         drive_ready_output <= cond.cmd_ready && cond.ctrl_pwr_ok && cond.main_pwr_ok && !any_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overload warning with filter
   dpso_ol_filt #(
      .UNIT_CYC(FILT_UNIT_CYC)
   ) u_ol (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .current(out_current),
      .thresh(cfg.ol_thresh),
      .filt(cfg.ol_filt),
      .warn(ol_warn)
   );
   assign overload_warning_output = ol_warn;

   // speed-limit indication and gravity offset, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_limit_output <= 1'b0;
         gravity_torque_offset <= 11'sd0;
      end else if (ce) begin
         speed_limit_output <= cond.speed_limited;
         gravity_torque_offset <= cfg.grav;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_phase_alarm_set: assert property (@(posedge pclk) disable iff (!presetn)
      ce && cfg.pl_en && cond.phase_lost |=> phase_alarm) else $error("phase loss not alarmed");
   a_phase_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !cfg.pl_en |=> !phase_alarm) else $error("phase alarm while disabled");
   a_enc_alarm_set: assert property (@(posedge pclk) disable iff (!presetn)
      ce && cfg.eb_en && cond.enc_broken |=> enc_alarm) else $error("encoder break not alarmed");
   a_enc_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !cfg.eb_en |=> !enc_alarm) else $error("encoder alarm while disabled");
   a_fault_out_off: assert property (@(posedge pclk) disable iff (!presetn)
      ce && any_fault |=> !fault_alarm_output) else $error("fault output on during fault");
   a_fault_level_on: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !any_fault && !cfg.sq_mode |=> fault_alarm_output) else $error("level mode not on");
   a_ready_gate: assert property (@(posedge pclk) disable iff (!presetn)
      drive_ready_output |-> $past(!any_fault && cond.main_pwr_ok)) else $error("ready during alarm");
   a_duty_range: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.duty >= DPSO_DUTY_MIN && cfg.duty <= DPSO_DUTY_MAX) else $error("duty out of range");
   a_speed_limit: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> speed_limit_output == $past(cond.speed_limited)) else $error("speed limit output lag");
   a_grav_range: assert property (@(posedge pclk) disable iff (!presetn)
      gravity_torque_offset <= DPSO_GRAV_MAX && gravity_torque_offset >= DPSO_GRAV_MIN)
      else $error("gravity offset out of range");

endmodule : dpso_top

// ---- dv/dpso_plc_model.sv ----
/*
   dpso_plc_model: host controller that watches the fault output and
   counts the cycles in which it reads on.
   assumes: outputs settle after each rising pclk edge; clr is bench driven.
*/
`timescale 1ns/1ps
module dpso_plc_model (
   input wire logic pclk,
   input wire logic clr,
   input wire logic fault_alarm_output,
   output int hi_cnt
);
   ////////////////////////////////////////////////////////////////////////////
   // on-time counter; clr opens a new window so duty is read over whole periods
   always_ff @(posedge pclk) begin
      if (clr) begin
         hi_cnt <= 0;
      end else begin
         // an unknown level counts as off, so it can never fake a match
         hi_cnt <= hi_cnt + ((fault_alarm_output === 1'b1) ? 1 : 0);
      end
   end
endmodule : dpso_plc_model

// ---- dv/drive_protection_status_outputs_tb_top.sv ----
/*
   testbench of dpso_top: apb master, plant stimulus and output checks.
   assumes: short square period (200) and filter unit (10) parameters.
*/
`timescale 1ns/1ps
module drive_protection_status_outputs_tb_top;
   import dpso_pkg::*;
   localparam int SQ_P = 200;                  // short square period
   localparam int FU = 10;                     // short filter unit
   localparam dpso_cond_t OK_C = 7'b0001110;   // powered, ready, no fault
   logic pclk, presetn, psel, penable, pwrite, clr, err;
   logic [7:0] paddr, acode;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, fault, rdy, warn, spd;
   logic signed [10:0] grav;
   logic [9:0] cur;
   dpso_cond_t cond;
   int fails, checked, hi;

   dpso_top #(.SQ_PERIOD_CYC(SQ_P), .FILT_UNIT_CYC(FU)) uut (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cond(cond), .out_current(cur),
      .fault_alarm_output(fault), .drive_ready_output(rdy),
      .overload_warning_output(warn), .speed_limit_output(spd),
      .gravity_torque_offset(grav), .alarm_code(acode));
   dpso_plc_model plc (.pclk(pclk), .clr(clr), .fault_alarm_output(fault), .hi_cnt(hi));

   ////////////////////////////////////////////////////////////////////////////
   // clock at 200 MHz
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; response and read data are taken at the edge that sees pready high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) fails++;
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick

   task automatic setc(input dpso_cond_t c);
      @(posedge pclk);
      cond <= c;
   endtask : setc

   task automatic setcur(input logic [9:0] v);
      @(posedge pclk);
      cur <= v;
   endtask : setcur

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      apb(1'b0, DPSO_CTRL_OFS, 32'h0);
      chk(rd, {29'h0, 1'b0, DPSO_EB_EN_RST, DPSO_PL_EN_RST});
      apb(1'b0, DPSO_DUTY_OFS, 32'h0);
      chk(rd, 32'(DPSO_DUTY_RST));
      apb(1'b0, DPSO_OLTH_OFS, 32'h0);
      chk(rd, 32'(DPSO_OLTH_RST));
      apb(1'b0, DPSO_OLFT_OFS, 32'h0);
      chk(rd, 32'(DPSO_OLFT_RST));
      chk(grav, 32'h0);
      chk({fault, rdy}, 32'h3);
      // unmapped place refuses, read-only code ignores the write
      apb(1'b1, 8'h1c, 32'hffff_ffff);
      chk(err, 32'h1);
      apb(1'b1, DPSO_ACODE_OFS, 32'h0000_00ff);
      apb(1'b0, DPSO_ACODE_OFS, 32'h0);
      chk(rd, 32'h0);
      $display("test reset done");
   endtask : t_reset

   // each protection: raise, disable clears it, re-enable with fault latches again
   task automatic t_alarm();
      dpso_cond_t c;
      for (int k = 0; k < 2; k++) begin
         c = OK_C;
         c[6 - k] = 1'b1;
         setc(c);
         tick(3);
         chk(fault, 32'h0);
         chk(rdy, 32'h0);
         chk(acode, k == 0 ? DPSO_PHASE_LOSS_ALARM_CODE : DPSO_ENCODER_BREAK_ALARM_CODE);
         apb(1'b1, DPSO_CTRL_OFS, k == 0 ? 32'h2 : 32'h1);
         tick(3);
         chk({fault, acode}, 32'h100);
         apb(1'b1, DPSO_CTRL_OFS, 32'h3);
         tick(3);
         chk(fault, 32'h0);
         setc(OK_C);
         apb(1'b1, DPSO_CTRL_OFS, 32'h0);
         apb(1'b1, DPSO_CTRL_OFS, 32'h3);
         tick(3);
         chk({fault, rdy}, 32'h3);
      end
      $display("test alarm done");
   endtask : t_alarm

   // loss of each readiness condition, then another fault
   task automatic t_ready();
      logic [6:0] m [4] = '{7'h08, 7'h04, 7'h02, 7'h10};
      for (int k = 0; k < 4; k++) begin
         setc(OK_C ^ m[k]);
         tick(3);
         chk(rdy, 32'h0);
         if (k == 3) chk(fault, 32'h0);
         setc(OK_C);
         tick(3);
         if (k < 3) chk(rdy, 32'h1);
      end
      $display("test ready done");
   endtask : t_ready

   task automatic t_speed();
      setc(OK_C | 7'h01);
      tick(1);
      chk(spd, 32'h1);
      setc(OK_C);
      tick(1);
      chk(spd, 32'h0);
      $display("test speed done");
   endtask : t_speed

   // on-time over one whole period, with clamping of the duty field
   task automatic t_square();
      logic [31:0] d [3] = '{32'd30, 32'd0, 32'd150};
      int e [3] = '{60, 2, 200};
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, DPSO_DUTY_OFS, d[k]);
         apb(1'b1, DPSO_CTRL_OFS, 32'h7);
         tick(SQ_P);
         @(posedge pclk);
         clr <= 1'b1;
         @(posedge pclk);
         clr <= 1'b0;
         tick(SQ_P);
         chk(hi, e[k]);
      end
      apb(1'b1, DPSO_CTRL_OFS, 32'h3);
      $display("test square done");
   endtask : t_square

   // threshold 50, filter 2 units = 20 cycles
   task automatic t_overload();
      apb(1'b1, DPSO_OLTH_OFS, 32'd50);
      apb(1'b1, DPSO_OLFT_OFS, 32'd2);
      setcur(10'd50);
      tick(15);
      chk(warn, 32'h0);
      tick(10);
      chk(warn, 32'h1);
      setcur(10'd49);
      tick(2);
      chk(warn, 32'h0);
      setcur(10'd60);
      tick(15);
      setcur(10'd10);
      setcur(10'd60);
      tick(15);
      chk(warn, 32'h0);
      tick(10);
      chk(warn, 32'h1);
      setcur(10'd0);
      apb(1'b1, DPSO_OLTH_OFS, 32'd1000);
      apb(1'b0, DPSO_OLTH_OFS, 32'h0);
      chk(rd, 32'(DPSO_OLTH_MAX));
      apb(1'b1, DPSO_OLFT_OFS, 32'd2000);
      apb(1'b0, DPSO_OLFT_OFS, 32'h0);
      chk(rd, 32'(DPSO_OLFT_MAX));
      $display("test overload done");
   endtask : t_overload

   task automatic t_grav();
      logic [31:0] w [3] = '{32'hffff_fffb, 32'd2000, 32'hffff_f830};
      logic [31:0] e [3] = '{32'hffff_fffb, 32'h0000_03e8, 32'hffff_fc18};
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, DPSO_GRAV_OFS, w[k]);
         tick(2);
         chk(grav, e[k]);
      end
      $display("test gravity done");
   endtask : t_grav

   ////////////////////////////////////////////////////////////////////////////
   // verdict, reached from the main sequence or the watchdog
   task automatic wrap_up();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, clr} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cond = OK_C;
      cur = 10'd0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      tick(3);
      t_reset();
      t_alarm();
      t_ready();
      t_speed();
      t_square();
      t_overload();
      t_grav();
      wrap_up();
   end

   // the whole run needs about 1500 cycles; cut a hang at 40000
   initial begin
      #(40000 * 5);
      fails++;
      wrap_up();
   end
endmodule : drive_protection_status_outputs_tb_top
